// ==== design/epsd_ctrl.sv ====
`timescale 1ns/1ps
// epsd_ctrl: external-port sdram controller with flyby dma strobes and host grant hand-off.
// assumes requests, grant request and setup writes are synchronous to core_clk_in.
module epsd_ctrl
   import epsd_pkg::*;
#(
   parameter int CHANNELS = EPSD_CHANNELS
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [CHANNELS-1:0] ext_dma_request_in,
   input wire logic cfg_wr_in,
   input wire logic [1:0] cfg_chan_in,
   input wire logic [EPSD_ADDR_W-1:0] cfg_addr_in,
   input wire logic cfg_is_write_in,
   input wire logic cfg_flyby_in,
   input wire logic bus_master_in,
   input wire logic bus_64_in,
   input wire logic refresh_req_in,
   input wire logic mode_req_in,
   input wire logic host_bus_request_in,
   output logic host_bus_grant_out,
   output logic host_bus_grant_oe_out,
   output logic [CHANNELS-1:0] done_out,
   output logic io_write_strobe_n_out,
   output logic io_read_strobe_n_out,
   output logic io_device_output_enable_n_out,
   output logic io_strobes_oe_out,
   output logic [3:0] sdram_bank_select_n_out,
   output logic sdram_bank_select_oe_out,
   output logic ras_n_out,
   output logic cas_n_out,
   output logic sdram_write_strobe_n_out,
   output logic low_word_data_mask_out,
   output logic high_word_data_mask_out,
   output logic sdram_addr_bit_ten_out,
   output logic [EPSD_ROW_W-1:0] sdram_addr_out,
   output logic sdram_clock_enable_pin_out,
   output logic sdram_oe_out
);
   // ****************************************************************
   // channel setup and request selection
   // ****************************************************************
   logic [CHANNELS-1:0] init_ff;
   logic [EPSD_ADDR_W+1:0] setup_rd;
   logic [1:0] sel_ff;
   logic [1:0] nxt_sel;
   logic pick;
   epsd_state_t state_ff;
   epsd_state_t nxt_state;
   logic [3:0] wait_ff;
   logic [CHANNELS-1:0] live_req;
   logic [1:0] rd_sel;

   // in idle the table is read at the channel about to win, so its setup word stands before activate
   assign rd_sel = (state_ff == EPSD_IDLE) ? nxt_sel : sel_ff;

   epsd_chan_table u_table (
      .core_clk_in(core_clk_in),
      .wr_idx_in(cfg_chan_in),
      .wr_en_in(cfg_wr_in),
      .wr_data_in({cfg_flyby_in, cfg_is_write_in, cfg_addr_in}),
      .rd_idx_in(rd_sel),
      .rd_data_out(setup_rd)
   );

   // a channel becomes usable only after its setup word is written
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         init_ff <= '0;
      end else if (cfg_wr_in) begin
         init_ff[cfg_chan_in] <= 1'b1;
      end
   end

   // requests masked by initialization, so uninitialized ones never start anything
   genvar gi;
   generate
      for (gi = 0; gi < CHANNELS; gi++) begin : g_req
         assign live_req[gi] = ext_dma_request_in[gi] & init_ff[gi];
      end
   endgenerate

   // lowest numbered live request wins
   always_comb begin
      nxt_sel = sel_ff;
      pick = 1'b0;
      for (int i = CHANNELS - 1; i >= 0; i--) begin
         if (live_req[i]) begin
            nxt_sel = 2'(i);
            pick = 1'b1;
         end
      end
   end

   // ****************************************************************
   // sequencer
   // ****************************************************************
   logic cur_write;
   logic cur_flyby;
   logic [EPSD_ADDR_W-1:0] cur_addr;
   logic cur_valid;
   assign cur_flyby = setup_rd[EPSD_ADDR_W+1];
   assign cur_write = setup_rd[EPSD_ADDR_W];
   assign cur_addr = setup_rd[EPSD_ADDR_W-1:0];
   // reserved upper half of each bank window is not sdram
   assign cur_valid = (cur_addr[EPSD_REGION_HI:EPSD_REGION_LO] == EPSD_REGION_SDRAM)
                      && !cur_addr[EPSD_RSV_BIT];
   // activate goes out only once the setup word is known good, never for a refused address
   logic act_go;
   assign act_go = (state_ff == EPSD_ACT) && cur_valid;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         EPSD_IDLE: begin
            if (host_bus_request_in) begin
               nxt_state = EPSD_SELF;
            end else if (refresh_req_in) begin
               nxt_state = EPSD_REFRESH;
            end else if (mode_req_in) begin
               nxt_state = EPSD_MODE;
            end else if (pick && bus_master_in) begin
               nxt_state = EPSD_ACT;
            end
         end
         EPSD_ACT: nxt_state = cur_valid ? EPSD_RCD : EPSD_IDLE;
         EPSD_RCD: nxt_state = (wait_ff <= EPSD_CNT_ONE) ? EPSD_RW : EPSD_RCD;
         EPSD_RW: nxt_state = EPSD_DATA;
         EPSD_DATA: nxt_state = EPSD_PRE;
         EPSD_PRE: nxt_state = EPSD_RP;
         EPSD_RP: nxt_state = (wait_ff <= EPSD_CNT_ONE) ? EPSD_IDLE : EPSD_RP;
         EPSD_REFRESH: nxt_state = EPSD_IDLE;
         EPSD_MODE: nxt_state = EPSD_IDLE;
         EPSD_SELF: nxt_state = EPSD_GRANT;
         EPSD_GRANT: nxt_state = host_bus_request_in ? EPSD_GRANT : EPSD_IDLE;
         default: nxt_state = EPSD_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         state_ff <= EPSD_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // channel choice is frozen once a transfer starts so the setup read stays stable
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         sel_ff <= 2'h0;
      end else if (state_ff == EPSD_IDLE) begin
         sel_ff <= nxt_sel;
      end
   end

   // wait counters for row-to-column and precharge delays
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         wait_ff <= EPSD_CNT_ZERO;
      end else if (state_ff == EPSD_ACT) begin
         wait_ff <= 4'(EPSD_TRCD_CYC); // activate leaves with this edge, so a full trcd count follows
      end else if (state_ff == EPSD_PRE) begin
         wait_ff <= 4'(EPSD_TRP_CYC - 1);
      end else if (wait_ff != EPSD_CNT_ZERO) begin
         wait_ff <= wait_ff - EPSD_CNT_ONE;
      end
   end

   // ****************************************************************
   // sdram pins
   // ****************************************************************
   logic [2:0] nxt_cmd;
   logic nxt_cs;
   always_comb begin
      nxt_cmd = EPSD_CMD_NOP;
      nxt_cs = 1'b0;
      case (nxt_state)
         EPSD_RCD: begin
            nxt_cmd = act_go ? EPSD_CMD_ACT : EPSD_CMD_NOP;
            nxt_cs = act_go;
         end
         EPSD_RW: begin
            nxt_cmd = cur_write ? EPSD_CMD_WR : EPSD_CMD_RD;
            nxt_cs = 1'b1;
         end
         EPSD_PRE: begin
            nxt_cmd = EPSD_CMD_PRE;
            nxt_cs = 1'b1;
         end
         EPSD_REFRESH, EPSD_SELF: begin
            nxt_cmd = EPSD_CMD_REF;
            nxt_cs = 1'b1;
         end
         EPSD_MODE: begin
            nxt_cmd = EPSD_CMD_MRS;
            nxt_cs = 1'b1;
         end
         default: begin
            nxt_cmd = EPSD_CMD_NOP;
            nxt_cs = 1'b0;
         end
      endcase
   end

   // command strobes, bank select and address; act only reached for valid region
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         {ras_n_out, cas_n_out, sdram_write_strobe_n_out} <= EPSD_CMD_NOP;
         sdram_bank_select_n_out <= 4'hF;
         sdram_addr_out <= '0;
         sdram_addr_bit_ten_out <= 1'b0;
      end else begin
         {ras_n_out, cas_n_out, sdram_write_strobe_n_out} <= nxt_cmd;
         sdram_bank_select_n_out <= 4'hF;
         if (nxt_cs) begin
            // refresh and mode hit every bank; reads and writes decode the bank field
            if (act_go || nxt_state == EPSD_RW) begin
               sdram_bank_select_n_out <= ~(4'h1 << cur_addr[EPSD_BANK_HI:EPSD_BANK_LO]);
            end else begin
               sdram_bank_select_n_out <= 4'h0;
            end
         end
         if (act_go) begin
            sdram_addr_out <= cur_addr[EPSD_ROW_LO +: EPSD_ROW_W];
            sdram_addr_bit_ten_out <= cur_addr[EPSD_ROW_LO + EPSD_A10_BIT];
         end else if (nxt_state == EPSD_RW) begin
            sdram_addr_out <= EPSD_ROW_W'(cur_addr[EPSD_COL_LO +: EPSD_COL_W]);
            sdram_addr_bit_ten_out <= 1'b0;
         end else begin
            // precharge all banks uses a10 high without touching the shared bus
            sdram_addr_bit_ten_out <= (nxt_state == EPSD_PRE);
         end
      end
   end

   // data masks, driven only with the write command (column strobe low)
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         low_word_data_mask_out <= 1'b0;
         high_word_data_mask_out <= 1'b0;
      end else if (nxt_state == EPSD_RW && cur_write) begin
         low_word_data_mask_out <= bus_64_in && cur_addr[EPSD_WORD_BIT];
         high_word_data_mask_out <= !bus_64_in || !cur_addr[EPSD_WORD_BIT];
      end else begin
         low_word_data_mask_out <= 1'b0;
         high_word_data_mask_out <= 1'b0;
      end
   end

   // clock enable: low from self-refresh entry until the host lets go
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         sdram_clock_enable_pin_out <= 1'b1;
      end else begin
         sdram_clock_enable_pin_out <= !(nxt_state == EPSD_SELF || nxt_state == EPSD_GRANT);
      end
   end

   // ****************************************************************
   // flyby strobes, enables and grant
   // ****************************************************************
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         io_write_strobe_n_out <= 1'b1;
         io_read_strobe_n_out <= 1'b1;
         io_device_output_enable_n_out <= 1'b1;
      end else begin
         io_write_strobe_n_out <= !(nxt_state == EPSD_DATA && cur_flyby && !cur_write);
         io_read_strobe_n_out <= !(nxt_state == EPSD_DATA && cur_flyby && cur_write);
         io_device_output_enable_n_out <= !(nxt_state == EPSD_DATA && cur_flyby && cur_write);
      end
   end

   // output enables: master only; all but the grant enable floated during host grant
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         sdram_oe_out <= 1'b0;
         sdram_bank_select_oe_out <= 1'b0;
         io_strobes_oe_out <= 1'b0;
         host_bus_grant_out <= 1'b1;
         host_bus_grant_oe_out <= 1'b0;
      end else begin
         sdram_oe_out <= bus_master_in && nxt_state != EPSD_GRANT;
         sdram_bank_select_oe_out <= bus_master_in && nxt_state != EPSD_GRANT;
         io_strobes_oe_out <= bus_master_in && nxt_state != EPSD_GRANT;
         host_bus_grant_out <= !(nxt_state == EPSD_GRANT);
         host_bus_grant_oe_out <= bus_master_in;
      end
   end

   // one-cycle completion pulse per channel at end of data cycle
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         done_out <= '0;
      end else begin
         done_out <= '0;
         if (state_ff == EPSD_DATA) begin
            done_out[sel_ff] <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   uninit_ignored_a: assert property (state_ff == EPSD_IDLE && (ext_dma_request_in & init_ff) == '0
      |=> state_ff != EPSD_ACT) else $error("uninitialized start");
   io_write_strobe_read_only_a: assert property (!io_write_strobe_n_out |-> cur_flyby && !cur_write)
      else $error("io write strobe off flyby read");
   io_read_strobe_with_oe_a: assert property (!io_read_strobe_n_out |-> !io_device_output_enable_n_out)
      else $error("io read without output enable");
   io_device_output_enable_flyby_a: assert property (!io_device_output_enable_n_out |-> cur_flyby)
      else $error("output enable outside flyby");
   bank_one_hot_a: assert property (!ras_n_out && cas_n_out && sdram_write_strobe_n_out
      |-> $onehot(~sdram_bank_select_n_out)) else $error("activate without single bank");
   act_region_a: assert property (!ras_n_out && cas_n_out && sdram_write_strobe_n_out |-> cur_valid)
      else $error("activate outside sdram space");
   master_only_a: assert property (!bus_master_in |=> !sdram_bank_select_oe_out)
      else $error("bank select driven by slave");
   act_then_rw_a: assert property ($rose(state_ff == EPSD_RCD) |-> ##[1:8] state_ff == EPSD_RW)
      else $error("column command late");
   read_mask_off_a: assert property (!cas_n_out && sdram_write_strobe_n_out
      |-> !low_word_data_mask_out && !high_word_data_mask_out) else $error("mask on read");
   mask_pair_a: assert property (low_word_data_mask_out |-> !high_word_data_mask_out)
      else $error("both masks set");
   cke_low_grant_a: assert property (!host_bus_grant_out |-> !sdram_clock_enable_pin_out && !sdram_oe_out)
      else $error("grant without self-refresh");
   grant_after_self_a: assert property (state_ff == EPSD_SELF |=> !host_bus_grant_out && !sdram_oe_out)
      else $error("grant not given");
   flyby_read_c: cover property (!io_write_strobe_n_out);
   flyby_write_c: cover property (!io_read_strobe_n_out);
   grant_c: cover property (!host_bus_grant_out ##1 host_bus_grant_out);
endmodule

// ==== include/epsd_pkg.sv ====
// epsd_pkg: constants, command codes and states for the external-port sdram / flyby block.
// assumes a single 125 MHz core clock; no software-visible registers.
package epsd_pkg;
   localparam int EPSD_CHANNELS = 4;
   localparam int EPSD_ADDR_W = 32;
   localparam int EPSD_ROW_W = 13;
   localparam int EPSD_COL_W = 10;
   localparam int EPSD_BANK_W = 2;
   // address field positions
   localparam int EPSD_REGION_HI = 31;
   localparam int EPSD_REGION_LO = 30;
   localparam logic [1:0] EPSD_REGION_SDRAM = 2'h1;
   localparam int EPSD_BANK_HI = 29;
   localparam int EPSD_BANK_LO = 28;
   localparam int EPSD_RSV_BIT = 27;
   localparam int EPSD_ROW_LO = 11;
   localparam int EPSD_COL_LO = 1;
   localparam int EPSD_WORD_BIT = 0;
   localparam int EPSD_A10_BIT = 10;
   // command encodings {ras_n, cas_n, we_n}
   localparam logic [2:0] EPSD_CMD_NOP = 3'h7;
   localparam logic [2:0] EPSD_CMD_ACT = 3'h3;
   localparam logic [2:0] EPSD_CMD_RD = 3'h5;
   localparam logic [2:0] EPSD_CMD_WR = 3'h4;
   localparam logic [2:0] EPSD_CMD_PRE = 3'h2;
   localparam logic [2:0] EPSD_CMD_REF = 3'h1;
   localparam logic [2:0] EPSD_CMD_MRS = 3'h0;
   // timing, in ns, and derived cycle counts at 125 MHz
   localparam int EPSD_CLK_PS = 8000;
   localparam int EPSD_TRCD_NS = 20;
   localparam int EPSD_TRP_NS = 20;
   localparam int EPSD_TRCD_CYC = (EPSD_TRCD_NS * 1000 + EPSD_CLK_PS - 1) / EPSD_CLK_PS;
   localparam int EPSD_TRP_CYC = (EPSD_TRP_NS * 1000 + EPSD_CLK_PS - 1) / EPSD_CLK_PS;
   localparam logic [3:0] EPSD_CNT_ONE = 4'h1;
   localparam logic [3:0] EPSD_CNT_ZERO = 4'h0;
   typedef enum logic [3:0] {
      EPSD_IDLE = 4'b0000,
      EPSD_ACT = 4'b0001,
      EPSD_RCD = 4'b0010,
      EPSD_RW = 4'b0011,
      EPSD_DATA = 4'b0100,
      EPSD_PRE = 4'b0101,
      EPSD_RP = 4'b0110,
      EPSD_REFRESH = 4'b0111,
      EPSD_MODE = 4'b1000,
      EPSD_SELF = 4'b1001,
      EPSD_GRANT = 4'b1010
   } epsd_state_t;
endpackage

// ==== design/epsd_chan_table.sv ====
`timescale 1ns/1ps
// epsd_chan_table: per-channel setup memory for external dma channels.
// assumes the owner writes setup words before raising the matching request; read data registered.
module epsd_chan_table
   import epsd_pkg::*;
#(
   parameter int WIDTH = EPSD_ADDR_W + 2,
   parameter int DEPTH = EPSD_CHANNELS
) (
   input wire logic core_clk_in,
   input wire logic [$clog2(DEPTH)-1:0] wr_idx_in,
   input wire logic wr_en_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic [$clog2(DEPTH)-1:0] rd_idx_in,
   output logic [WIDTH-1:0] rd_data_out
);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   // one write port, one registered read port
   always_ff @(posedge core_clk_in) begin
      if (wr_en_in) begin
         mem_ff[wr_idx_in] <= wr_data_in;
      end
      rd_data_out <= mem_ff[rd_idx_in];
   end
endmodule

// ==== tb/epsd_mem_model.sv ====
`timescale 1ns/1ps
// epsd_mem_model: behavioural sdram plus flyby io device facing epsd_ctrl.
// assumes all pins are synchronous to core_clk_in; dq wires are not modelled, only counted.
module epsd_mem_model
   import epsd_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic ras_n_in,
   input wire logic cas_n_in,
   input wire logic we_n_in,
   input wire logic cke_in,
   input wire logic [3:0] bank_sel_n_in,
   input wire logic sdram_oe_in,
   input wire logic low_mask_in,
   input wire logic high_mask_in,
   input wire logic io_wr_n_in,
   input wire logic io_rd_n_in,
   input wire logic io_oe_n_in,
   input wire logic io_strobes_oe_in,
   output logic [7:0] proto_err_out,
   output logic [7:0] io_sample_cnt_out,
   output logic [7:0] io_drive_cnt_out
);
   logic [3:0] open_ff;
   logic self_ff;
   logic [2:0] cmd;
   // ***************************************************
   // command decode
   // ***************************************************
   assign cmd = {ras_n_in, cas_n_in, we_n_in};
   // a column command to a closed bank, or a masked read, is counted as a fault
   always @(posedge core_clk_in) begin
      if (rst_in) begin
         open_ff <= 4'h0;
         self_ff <= 1'b0;
         proto_err_out <= 8'h00;
      end else if (self_ff) begin
         self_ff <= !cke_in;
      end else if (sdram_oe_in) begin
         case (cmd)
            EPSD_CMD_ACT: open_ff <= open_ff | ~bank_sel_n_in;
            EPSD_CMD_RD, EPSD_CMD_WR: begin
               if ((open_ff & ~bank_sel_n_in) == 4'h0 || (cmd == EPSD_CMD_RD && (low_mask_in || high_mask_in))) begin
                  proto_err_out <= proto_err_out + 8'h01;
               end
            end
            EPSD_CMD_PRE: open_ff <= 4'h0;
            EPSD_CMD_REF: self_ff <= !cke_in;
            default: ;
         endcase
      end
   end
   // io device samples under the write strobe, drives only with read strobe and enable both low
   always @(posedge core_clk_in) begin
      if (rst_in) begin
         io_sample_cnt_out <= 8'h00;
         io_drive_cnt_out <= 8'h00;
      end else if (io_strobes_oe_in) begin
         if (!io_wr_n_in) io_sample_cnt_out <= io_sample_cnt_out + 8'h01;
         if (!io_rd_n_in && !io_oe_n_in) io_drive_cnt_out <= io_drive_cnt_out + 8'h01;
      end
   end
endmodule

// ==== tb/epsd_ctrl_tb.sv ====
`timescale 1ns/1ps
// epsd_ctrl_tb: self-checking bench for epsd_ctrl with the far-side model beside it.
// assumes one 125 MHz clock; inputs change on the falling edge and outputs are read there.
module epsd_ctrl_tb;
   import epsd_pkg::*;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [3:0] ext_dma_request = 4'h0;
   logic cfg_wr = 1'b0;
   logic [1:0] cfg_chan = 2'h0;
   logic [31:0] cfg_addr = 32'h0;
   logic cfg_is_write = 1'b0;
   logic cfg_flyby = 1'b0;
   logic bus_master = 1'b1;
   logic bus_64 = 1'b0;
   logic refresh_req = 1'b0;
   logic mode_req = 1'b0;
   logic host_req = 1'b0;
   logic grant_n, grant_oe, io_oe, sel_oe, ras_n, cas_n, we_n, lmask, hmask, a10, cke, sd_oe, iow_n, ior_n, io_device_output_enable_n;
   logic [3:0] done, sel_n;
   logic [12:0] row;
   logic [7:0] perr, n_smp, n_drv;
   logic [31:0] rng = 32'h000065D1;
   int n_fail = 0;
   int samples_checked = 0;

   always #4 core_clk_in = ~core_clk_in;

   epsd_ctrl epsd_ctrl_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .ext_dma_request_in(ext_dma_request),
      .cfg_wr_in(cfg_wr), .cfg_chan_in(cfg_chan), .cfg_addr_in(cfg_addr), .cfg_is_write_in(cfg_is_write),
      .cfg_flyby_in(cfg_flyby), .bus_master_in(bus_master), .bus_64_in(bus_64), .refresh_req_in(refresh_req),
      .mode_req_in(mode_req), .host_bus_request_in(host_req), .host_bus_grant_out(grant_n),
      .host_bus_grant_oe_out(grant_oe), .done_out(done), .io_write_strobe_n_out(iow_n),
      .io_read_strobe_n_out(ior_n), .io_device_output_enable_n_out(io_device_output_enable_n), .io_strobes_oe_out(io_oe),
      .sdram_bank_select_n_out(sel_n), .sdram_bank_select_oe_out(sel_oe), .ras_n_out(ras_n), .cas_n_out(cas_n),
      .sdram_write_strobe_n_out(we_n), .low_word_data_mask_out(lmask), .high_word_data_mask_out(hmask),
      .sdram_addr_bit_ten_out(a10), .sdram_addr_out(row), .sdram_clock_enable_pin_out(cke), .sdram_oe_out(sd_oe));

   epsd_mem_model epsd_mem_model_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .ras_n_in(ras_n),
      .cas_n_in(cas_n), .we_n_in(we_n), .cke_in(cke), .bank_sel_n_in(sel_n), .sdram_oe_in(sd_oe),
      .low_mask_in(lmask), .high_mask_in(hmask), .io_wr_n_in(iow_n), .io_rd_n_in(ior_n), .io_oe_n_in(io_device_output_enable_n),
      .io_strobes_oe_in(io_oe), .proto_err_out(perr), .io_sample_cnt_out(n_smp), .io_drive_cnt_out(n_drv));

   // ***************************************************
   // helpers
   // ***************************************************
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   // {high, low}: reads never mask; a write on a 32-bit bus always masks the high half
   function automatic logic [1:0] exp_mask(input logic wr, input logic b64, input logic odd);
      return wr ? {!odd || !b64, b64 && odd} : 2'h0;
   endfunction
   // {write strobe, read strobe, enable}, all active low
   function automatic logic [2:0] exp_io(input logic wr, input logic fly);
      return fly ? (wr ? 3'h4 : 3'h3) : 3'h7;
   endfunction
   task automatic check(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk_in);
   endtask
   task automatic wait_cmd(input logic [2:0] c, input int max, input string msg);
      int k;
      k = 0;
      while ({ras_n, cas_n, we_n} !== c && k < max) begin
         tick(1);
         k++;
      end
      check({ras_n, cas_n, we_n} === c, msg);
   endtask
   // no row opened; a master keeps selects idle, a non-master lets them float
   task automatic quiet(input int n, input string msg);
      logic bad;
      bad = 1'b0;
      repeat (n) begin
         tick(1);
         bad |= (ras_n === 1'b0 && sd_oe === 1'b1) || (bus_master ? sel_n !== 4'hF : sel_oe !== 1'b0);
      end
      check(!bad, msg);
   endtask
   task automatic setup(input logic [1:0] ch, input logic [31:0] a, input logic wr, input logic fly);
      cfg_wr = 1'b1;
      cfg_chan = ch;
      cfg_addr = a;
      cfg_is_write = wr;
      cfg_flyby = fly;
      tick(1);
      cfg_wr = 1'b0;
      tick(2);
   endtask
   task automatic dma_run(input logic [1:0] ch, input logic [31:0] a, input logic wr, input logic fly);
      logic [7:0] s0, d0;
      s0 = n_smp;
      d0 = n_drv;
      setup(ch, a, wr, fly);
      ext_dma_request[ch] = 1'b1;
      wait_cmd(EPSD_CMD_ACT, 6, "no activate");
      ext_dma_request[ch] = 1'b0;
      check(sel_n === ~(4'h1 << a[29:28]) && sel_oe === 1'b1, "bank select");
      check(row === a[23:11] && a10 === a[21], "row address");
      tick(3);
      check({ras_n, cas_n, we_n} === (wr ? EPSD_CMD_WR : EPSD_CMD_RD), "column command");
      check({hmask, lmask} === exp_mask(wr, bus_64, a[0]), "data masks");
      tick(1);
      check({iow_n, ior_n, io_device_output_enable_n} === exp_io(wr, fly) && io_oe === 1'b1, "io strobes");
      tick(1);
      check({ras_n, cas_n, we_n} === EPSD_CMD_PRE && done === (4'h1 << ch), "precharge and done");
      tick(4);
      check(n_smp - s0 === 8'(fly && !wr) && n_drv - d0 === 8'(fly && wr) && perr === 8'h00, "far side");
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      logic [31:0] r, r2;
      int k;
      tick(15);
      check({ras_n, cas_n, we_n, sel_n, hmask, lmask, cke, grant_n, grant_oe, io_oe, sel_oe, sd_oe} === 15'h7F30,
            "reset values");
      tick(1);
      rst_in = 1'b0;
      tick(1);
      ext_dma_request[3] = 1'b1;
      quiet(15, "unset channel ran");
      ext_dma_request[3] = 1'b0;
      // first four runs sweep word parity against bus width, the rest are random
      for (int i = 0; i < 16; i++) begin
         r = rnd();
         r2 = rnd();
         bus_64 = i < 4 ? i[1] : r[31];
         if (i < 4) r[0] = i[0];
         dma_run(r2[1:0], {2'h1, r[29:28], 1'b0, r[26:0]}, i < 4 || r2[2], i < 4 || r2[3]);
      end
      for (int j = 0; j < 2; j++) begin
         setup(2'h1, j ? 32'h48000000 : 32'h80000000, 1'b1, 1'b1);
         ext_dma_request[1] = 1'b1;
         quiet(12, "foreign or reserved space ran");
         ext_dma_request[1] = 1'b0;
         tick(1);
      end
      setup(2'h2, 32'h40000800, 1'b0, 1'b1);
      bus_master = 1'b0;
      ext_dma_request[2] = 1'b1;
      quiet(12, "non-master drove selects");
      ext_dma_request[2] = 1'b0;
      bus_master = 1'b1;
      tick(2);
      refresh_req = 1'b1;
      wait_cmd(EPSD_CMD_REF, 10, "no refresh");
      refresh_req = 1'b0;
      tick(6);
      mode_req = 1'b1;
      wait_cmd(EPSD_CMD_MRS, 10, "no mode set");
      mode_req = 1'b0;
      tick(6);
      host_req = 1'b1;
      k = 0;
      while (grant_n !== 1'b0 && k < 8) begin
         tick(1);
         k++;
      end
      repeat (6) begin
         tick(1);
         check(grant_n === 1'b0 && grant_oe === 1'b1 && cke === 1'b0 && {sd_oe, sel_oe, io_oe} === 3'h0,
               "host hand-off");
      end
      host_req = 1'b0;
      tick(3);
      check(grant_n === 1'b1 && cke === 1'b1, "grant not returned");
      bus_64 = 1'b1;
      dma_run(2'h0, 32'h77FFFFFF, 1'b1, 1'b1);
      end_of_test();
   end

   // the sequence needs well under 2000 cycles; 5000 only trips on a hang
   initial begin
      #40000;
      n_fail++;
      end_of_test();
   end
endmodule
